// >>> host_bus_pkg.sv
package host_bus_pkg;

    // bus widths
    localparam int ADDR_W     = 32;
    localparam int DATA_W     = 64;
    localparam int GROUP_W    = 16;
    localparam int GROUPS     = 4;
    localparam int POP_W      = 5;
    localparam logic [4:0] INV_LIMIT = 5'h08;

    // transfer rates of the processor bus in MT/s and their select codes
    localparam int RATE_400_MTS = 400;
    localparam int RATE_533_MTS = 533;
    localparam int RATE_800_MTS = 800;
    localparam logic [1:0] RATE_400 = 2'h0;
    localparam logic [1:0] RATE_533 = 2'h1;
    localparam logic [1:0] RATE_800 = 2'h2;

    // bus pumping and line geometry
    localparam int ADDR_PUMP      = 2;
    localparam int DATA_PUMP      = 4;
    localparam int LINE_BYTES     = 64;
    localparam int LINE_OFS_W     = 6;
    localparam int LINE_CLOCKS    = LINE_BYTES / (DATA_PUMP * DATA_W / 8);
    localparam int REQ_SPACING    = 2;

    // queue limits
    localparam int QUEUE_DEPTH    = 12;
    localparam int QUEUE_CNT_W    = 4;
    localparam int DEFER_MAX      = 1;

    // interrupt message region: address bits 31:20
    localparam int         MSG_HI     = 31;
    localparam int         MSG_LO     = 20;
    localparam logic [11:0] MSG_REGION = 12'hFEE;

    // configuration access ports in i/o space, cf8..cff
    localparam int          IO_W        = 16;
    localparam logic [12:0] CFG_IO_PAGE = 13'h019F;

    // window granularity: base and limit carry address bits 31:20
    localparam int WIN_LO = 20;

    // reset values
    localparam logic [QUEUE_CNT_W-1:0] QUEUE_RESET = 4'h0;

    typedef enum logic [1:0] {
        TGT_GFX = 2'b00,
        TGT_HUB = 2'b01,
        TGT_CFG = 2'b10,
        TGT_MEM = 2'b11
    } target_e;

    typedef enum logic {
        IB_SNOOP  = 1'b0,
        IB_INTMSG = 1'b1
    } inbound_kind_e;

    typedef enum logic {
        SRC_HUB = 1'b0,
        SRC_GFX = 1'b1
    } source_e;

endpackage

// >>> host_bus_interface_dbi.sv
`timescale 1ns/1ps

module host_bus_interface_dbi #(
    parameter int FIFO_DEPTH = 2,
    parameter int FIFO_AW    = 1
) (
    input  wire logic        clk,               // core clock, 10 MHz
    input  wire logic        rst_n,             // async reset, active low
    input  wire logic        bus_clk,           // processor bus clock
    // inbound accesses from hub and graphics ports (core domain)
    input  wire logic        in_valid,          // inbound access present
    input  wire logic        in_src,            // source_e of the access
    input  wire logic        in_pci_sem,        // graphics access, pci rules
    input  wire logic        in_write,          // access is a write
    input  wire logic        in_noncache,       // target non-cacheable
    input  wire logic        in_hits_memory,    // target is system memory
    input  wire logic [31:0] in_addr,           // inbound address
    input  wire logic [63:0] in_data,           // inbound write data
    output logic             in_posted,         // pulse, access buffered
    output logic             in_retry,          // pulse, retry on the port
    // host request phase (bus domain)
    input  wire logic [1:0]  bus_rate_sel,      // rate select code
    output logic             rate_ok,           // select code is supported
    input  wire logic        req_valid,         // host request present
    input  wire logic [31:0] req_addr,          // host request address
    input  wire logic        req_io,            // i/o cycle, else memory
    input  wire logic        req_defer,         // request will be deferred
    output logic             req_ready,         // request taken when high
    input  wire logic        txn_done,          // pulse, queue entry retired
    input  wire logic        defer_done,        // pulse, deferred reply seen
    output logic [3:0]       queue_count,       // queue occupancy
    output logic             defer_busy,        // deferred txn outstanding
    // decode windows (bus domain, static while traffic runs)
    input  wire logic [11:0] gfx_mem_base,      // graphics window base 31:20
    input  wire logic [11:0] gfx_mem_limit,     // graphics window limit
    input  wire logic        gfx_mem_en,        // graphics window enabled
    input  wire logic [15:0] gfx_io_base,       // graphics i/o base
    input  wire logic [15:0] gfx_io_limit,      // graphics i/o limit
    input  wire logic [31:0] aper_base,         // aperture base
    input  wire logic [31:0] aper_mask,         // aperture size mask
    input  wire logic [31:0] top_of_mem,        // top of system memory
    output logic             route_valid,       // pulse, decode result
    output logic [1:0]       route_target,      // target_e of the cycle
    output logic             route_translate,   // aperture hit, translate
    output logic [31:0]      route_addr,        // decoded address
    // inbound transaction issue to the processor bus (bus domain)
    output logic             ib_valid,          // snoop or message pending
    output logic             ib_kind,           // inbound_kind_e
    output logic [31:0]      ib_addr,           // issued address
    input  wire logic        ib_ready,          // bus took the transaction
    // data pins, active low, split into in, out and enable
    input  wire logic [63:0] host_data_lines_n_i,   // lines as sampled
    output logic [63:0]      host_data_lines_n_o,   // lines as driven
    output logic             host_data_lines_oe_n,  // low while driving
    input  wire logic [3:0]  data_invert_flags_n_i, // flags as sampled
    output logic [3:0]       data_invert_flags_n_o, // flags as driven
    output logic             data_invert_flags_oe_n,// low while driving
    input  wire logic        data_strobe,       // pin, data phase valid
    output logic             rx_valid,          // pulse, rx_data valid
    output logic [63:0]      rx_data            // received, re-inverted
);

    localparam int HOLD_W = 1 + host_bus_pkg::ADDR_W + host_bus_pkg::DATA_W;

    // ------------------------------------------------------------ core side
    logic                 fwd_snoop;
    logic                 fwd_msg;
    logic                 need_post;
    logic                 push;
    logic                 pop;
    logic                 fifo_full;
    logic                 fifo_empty;
    logic [HOLD_W-1:0]    fifo_mem [FIFO_DEPTH];
    logic [FIFO_AW-1:0]   wr_ptr_q;
    logic [FIFO_AW-1:0]   rd_ptr_q;
    logic [FIFO_AW:0]     fifo_cnt_q;
    logic [HOLD_W-1:0]    push_word;
    logic [HOLD_W-1:0]    hold_q;
    logic                 hs_busy_q;
    logic                 req_tgl_q;
    logic                 ack_s1_q;
    logic                 ack_s2_q;
    logic                 ack_seen_q;
    logic                 ack_tgl_q;
    logic                 in_posted_q;
    logic                 in_retry_q;

    // snoop needed only for coherent traffic to memory
    always_comb begin
        fwd_snoop = in_hits_memory &&
                    ((in_src == host_bus_pkg::SRC_HUB) || in_pci_sem);
        if ((in_src == host_bus_pkg::SRC_GFX) && in_noncache && !in_pci_sem)
        begin
            fwd_snoop = 1'b0;
        end
    end

    // interrupt region writes from qualifying sources
    assign fwd_msg = in_write &&
        (in_addr[host_bus_pkg::MSG_HI:host_bus_pkg::MSG_LO] ==
         host_bus_pkg::MSG_REGION) &&
        ((in_src == host_bus_pkg::SRC_HUB) || in_pci_sem);

    assign need_post  = in_valid && (fwd_msg || fwd_snoop);
    assign fifo_full  = (fifo_cnt_q == (FIFO_AW+1)'(FIFO_DEPTH));
    assign fifo_empty = (fifo_cnt_q == '0);
    assign push       = need_post && !fifo_full;
    assign pop        = !fifo_empty && !hs_busy_q;

    // a message wins over a snoop for the same write
    assign push_word = {fwd_msg ? host_bus_pkg::IB_INTMSG
                                : host_bus_pkg::IB_SNOOP,
                        in_addr, in_data};

    // storage has no reset; only pointers and count carry control state
    always_ff @(posedge clk) begin
        if (push) begin
            fifo_mem[wr_ptr_q] <= push_word;
        end
    end

    // fifo pointers; the handshake drains it, so a slow bus fills it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_q   <= '0;
            rd_ptr_q   <= '0;
            fifo_cnt_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                fifo_cnt_q <= fifo_cnt_q + 1'b1;
            end else if (pop && !push) begin
                fifo_cnt_q <= fifo_cnt_q - 1'b1;
            end
        end
    end

    // port answers: posted when space, retried when full
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            in_posted_q <= 1'b0;
            in_retry_q  <= 1'b0;
        end else begin
            in_posted_q <= push;
            in_retry_q  <= need_post && fifo_full;
        end
    end

    assign in_posted = in_posted_q;
    assign in_retry  = in_retry_q;

    // toggle handshake toward the bus domain; hold_q is stable until ack
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_q     <= '0;
            hs_busy_q  <= 1'b0;
            req_tgl_q  <= 1'b0;
            ack_seen_q <= 1'b0;
        end else begin
            if (pop) begin
                hold_q    <= fifo_mem[rd_ptr_q];
                hs_busy_q <= 1'b1;
                req_tgl_q <= ~req_tgl_q;
            end else if (ack_s2_q != ack_seen_q) begin
                hs_busy_q  <= 1'b0;
                ack_seen_q <= ack_s2_q;
            end
        end
    end

    // ack toggle synchroniser
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_tgl_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    // ------------------------------------------------------------- bus side
    logic                 req_s1_q;
    logic                 req_s2_q;
    logic                 req_seen_q;
    logic                 ib_valid_q;
    logic                 ib_kind_q;
    logic [31:0]          ib_addr_q;
    logic [63:0]          ib_data_q;
    logic [63:0]          enc_lines;
    logic [3:0]           enc_flags;
    logic [63:0]          dout_q;
    logic [3:0]           fout_q;
    logic                 drive_q;
    logic [63:0]          rx_s1_q;
    logic [63:0]          rx_s2_q;
    logic [3:0]           rxf_s1_q;
    logic [3:0]           rxf_s2_q;
    logic                 stb_s1_q;
    logic                 stb_s2_q;
    logic [63:0]          dec_data;
    logic [63:0]          rx_data_q;
    logic                 rx_valid_q;
    logic                 take;
    logic                 gap_q;
    logic [3:0]           queue_cnt_q;
    logic                 defer_q;
    logic                 rate_ok_q;
    logic                 route_valid_q;
    logic [1:0]           route_target_q;
    logic                 route_translate_q;
    logic [31:0]          route_addr_q;
    logic [1:0]           dec_target;
    logic                 aper_hit;
    logic                 gfx_mem_hit;
    logic                 gfx_io_hit;
    logic                 cfg_hit;

    // request toggle synchroniser
    always_ff @(posedge bus_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
        end else begin
            req_s1_q <= req_tgl_q;
            req_s2_q <= req_s1_q;
        end
    end

    // inbound issue: word captured once the toggle has settled
    always_ff @(posedge bus_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_seen_q <= 1'b0;
            ack_tgl_q  <= 1'b0;
            ib_valid_q <= 1'b0;
            ib_kind_q  <= host_bus_pkg::IB_SNOOP;
            ib_addr_q  <= '0;
            ib_data_q  <= '0;
        end else begin
            if (ib_valid_q && ib_ready) begin
                ib_valid_q <= 1'b0;
                ack_tgl_q  <= ~ack_tgl_q;
            end else if (!ib_valid_q && (req_s2_q != req_seen_q)) begin
                req_seen_q <= req_s2_q;
                ib_valid_q <= 1'b1;
                ib_kind_q  <= hold_q[HOLD_W-1];
                ib_data_q  <= hold_q[63:0];
                if (hold_q[HOLD_W-1] == host_bus_pkg::IB_SNOOP) begin
                    ib_addr_q <= {hold_q[95:70],
                                  {host_bus_pkg::LINE_OFS_W{1'b0}}};
                end else begin
                    ib_addr_q <= hold_q[95:64];
                end
            end
        end
    end

    assign ib_valid = ib_valid_q;
    assign ib_kind  = ib_kind_q;
    assign ib_addr  = ib_addr_q;

    // per-group inversion, pure logic of the current phase only
    for (genvar g = 0; g < host_bus_pkg::GROUPS; g++) begin : g_inv
        logic [15:0] tx_grp;
        logic [15:0] rx_grp;
        logic [4:0]  low_cnt;
        assign tx_grp = ib_data_q[g*16 +: 16];
        assign rx_grp = rx_s2_q[g*16 +: 16];
        // a logical one drives an active-low line low
        always_comb begin
            low_cnt = '0;
            for (int b = 0; b < host_bus_pkg::GROUP_W; b++) begin
                low_cnt = low_cnt + {4'h0, tx_grp[b]};
            end
        end
        assign enc_flags[g] = !(low_cnt > host_bus_pkg::INV_LIMIT);
        assign enc_lines[g*16 +: 16] = enc_flags[g] ? ~tx_grp
                                                    : tx_grp;
        assign dec_data[g*16 +: 16] = rxf_s2_q[g] ? ~rx_grp
                                                  : rx_grp;
    end

    // one data phase driven when a message is taken; snoops carry no data
    always_ff @(posedge bus_clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_q  <= '1;
            fout_q  <= '1;
            drive_q <= 1'b0;
        end else begin
            drive_q <= ib_valid_q && ib_ready &&
                       (ib_kind_q == host_bus_pkg::IB_INTMSG);
            if (ib_valid_q && ib_ready) begin
                dout_q <= enc_lines;
                fout_q <= enc_flags;
            end
        end
    end

    assign host_data_lines_n_o    = dout_q;
    assign data_invert_flags_n_o  = fout_q;
    assign host_data_lines_oe_n   = !drive_q;
    assign data_invert_flags_oe_n = !drive_q;

    // pin samples pass two flops before decoding
    always_ff @(posedge bus_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_s1_q  <= '1;
            rx_s2_q  <= '1;
            rxf_s1_q <= '1;
            rxf_s2_q <= '1;
            stb_s1_q <= 1'b0;
            stb_s2_q <= 1'b0;
        end else begin
            rx_s1_q  <= host_data_lines_n_i;
            rx_s2_q  <= rx_s1_q;
            rxf_s1_q <= data_invert_flags_n_i;
            rxf_s2_q <= rxf_s1_q;
            stb_s1_q <= data_strobe;
            stb_s2_q <= stb_s1_q;
        end
    end

    // received data and flags decoded on strobed phases only; rx_data holds otherwise
    always_ff @(posedge bus_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_valid_q <= 1'b0;
            rx_data_q  <= '0;
        end else begin
            rx_valid_q <= stb_s2_q;
            if (stb_s2_q) begin
                rx_data_q <= dec_data;
            end
        end
    end

    assign rx_valid = rx_valid_q;
    assign rx_data  = rx_data_q;

    // window hits; the graphics memory window is 1 MB aligned, limits inclusive
    assign aper_hit    = ((req_addr & aper_mask) == (aper_base & aper_mask));
    assign gfx_mem_hit = gfx_mem_en &&
        (req_addr[31:host_bus_pkg::WIN_LO] >= gfx_mem_base) &&
        (req_addr[31:host_bus_pkg::WIN_LO] <= gfx_mem_limit);
    assign gfx_io_hit  = (req_addr[15:0] >= gfx_io_base) &&
                         (req_addr[15:0] <= gfx_io_limit);
    assign cfg_hit     = (req_addr[15:3] == host_bus_pkg::CFG_IO_PAGE);

    // exactly one target per cycle by priority
    always_comb begin
        if (req_io) begin
            if (cfg_hit) begin
                dec_target = host_bus_pkg::TGT_CFG;
            end else if (gfx_io_hit) begin
                dec_target = host_bus_pkg::TGT_GFX;
            end else begin
                dec_target = host_bus_pkg::TGT_HUB;
            end
        end else begin
            if (aper_hit) begin
                dec_target = host_bus_pkg::TGT_MEM;
            end else if (gfx_mem_hit) begin
                dec_target = host_bus_pkg::TGT_GFX;
            end else if (req_addr < top_of_mem) begin
                dec_target = host_bus_pkg::TGT_MEM;
            end else begin
                dec_target = host_bus_pkg::TGT_HUB;
            end
        end
    end

    // taking a request: spacing, queue room and deferral limit
    assign req_ready = !gap_q &&
        (queue_cnt_q < 4'(host_bus_pkg::QUEUE_DEPTH)) &&
        !(req_defer && defer_q);
    assign take = req_valid && req_ready;

    // a request blocks the next clock, giving one every second clock
    always_ff @(posedge bus_clk or negedge rst_n) begin
        if (!rst_n) begin
            gap_q <= 1'b0;
        end else begin
            gap_q <= take && (host_bus_pkg::REQ_SPACING > 1);
        end
    end

    // in-order queue occupancy; a retire never underflows
    always_ff @(posedge bus_clk or negedge rst_n) begin
        if (!rst_n) begin
            queue_cnt_q <= host_bus_pkg::QUEUE_RESET;
        end else if (take && !(txn_done && (queue_cnt_q != '0))) begin
            queue_cnt_q <= queue_cnt_q + 1'b1;
        end else if (!take && txn_done && (queue_cnt_q != '0)) begin
            queue_cnt_q <= queue_cnt_q - 1'b1;
        end
    end

    // deferred tracking; in the clear cycle a new deferral is refused, req_ready low
    always_ff @(posedge bus_clk or negedge rst_n) begin
        if (!rst_n) begin
            defer_q <= 1'b0;
        end else if (take && req_defer) begin
            defer_q <= 1'b1;
        end else if (defer_done) begin
            defer_q <= 1'b0;
        end
    end

    assign queue_count = queue_cnt_q;
    assign defer_busy  = defer_q;

    // decode result registered one clock after the take
    always_ff @(posedge bus_clk or negedge rst_n) begin
        if (!rst_n) begin
            route_valid_q     <= 1'b0;
            route_target_q    <= host_bus_pkg::TGT_HUB;
            route_translate_q <= 1'b0;
            route_addr_q      <= '0;
        end else begin
            route_valid_q <= take;
            if (take) begin
                route_target_q    <= dec_target;
                route_translate_q <= !req_io && aper_hit;
                route_addr_q      <= req_addr;
            end
        end
    end

    assign route_valid     = route_valid_q;
    assign route_target    = route_target_q;
    assign route_translate = route_translate_q;
    assign route_addr      = route_addr_q;

    // rate select check
    always_ff @(posedge bus_clk or negedge rst_n) begin
        if (!rst_n) begin
            rate_ok_q <= 1'b0;
        end else begin
            rate_ok_q <= (bus_rate_sel == host_bus_pkg::RATE_400) ||
                         (bus_rate_sel == host_bus_pkg::RATE_533) ||
                         (bus_rate_sel == host_bus_pkg::RATE_800);
        end
    end

    assign rate_ok = rate_ok_q;

endmodule

// >>> host_bus_interface_dbi_checker.sv
`timescale 1ns/1ps
// handshake and drive relations seen at the top ports
module host_bus_interface_dbi_checker (
    input wire logic        clk, rst_n, bus_clk, in_valid, in_posted, in_retry,
    input wire logic        req_valid, req_ready, req_defer, defer_busy,
    input wire logic        route_valid, ib_valid, ib_kind, ib_ready,
    input wire logic        host_data_lines_oe_n,
    input wire logic [3:0]  queue_count, data_invert_flags_n_o,
    input wire logic [31:0] ib_addr,
    input wire logic [63:0] host_data_lines_n_o
);
    property p_gap; @(posedge bus_clk) disable iff (!rst_n)
        req_valid && req_ready |=> !req_ready; endproperty
    a_gap: assert property (p_gap) else $error("take in gap");
    property p_route; @(posedge bus_clk) disable iff (!rst_n)
        req_valid && req_ready |=> route_valid ##1 !route_valid; endproperty
    a_route: assert property (p_route) else $error("no route");
    property p_queue; @(posedge bus_clk) disable iff (!rst_n)
        queue_count >= 4'hC |-> queue_count == 4'hC && !req_ready; endproperty
    a_queue: assert property (p_queue) else $error("queue overrun");
    property p_defer; @(posedge bus_clk) disable iff (!rst_n)
        req_defer && defer_busy |-> !req_ready; endproperty
    a_defer: assert property (p_defer) else $error("second defer");
    property p_align; @(posedge bus_clk) disable iff (!rst_n)
        ib_valid && !ib_kind |-> ib_addr[5:0] == 6'h00; endproperty
    a_align: assert property (p_align) else $error("snoop unaligned");
    property p_drive; @(posedge bus_clk) disable iff (!rst_n)
        ib_valid && ib_ready && ib_kind |=>
        !host_data_lines_oe_n ##1 host_data_lines_oe_n; endproperty
    a_drive: assert property (p_drive) else $error("drive length");
    // at most 8 lines of the top group (63:48) low, at most 7 once inverted
    property p_inv; @(posedge bus_clk) disable iff (!rst_n)
        !host_data_lines_oe_n |-> $countones(host_data_lines_n_o[63:48])
        >= (data_invert_flags_n_o[3] ? 8 : 9); endproperty
    a_inv: assert property (p_inv) else $error("bad inversion");
    property p_in; @(posedge clk) disable iff (!rst_n)
        in_posted || in_retry |-> $past(in_valid)
        && !(in_posted && in_retry); endproperty
    a_in: assert property (p_in) else $error("stray answer");
endmodule

// >>> bus_partner.sv
`timescale 1ns/1ps
// processor side: stalls inbound issue and sends encoded data words
module bus_partner (
    input  wire logic        bus_clk,  // bus clock
    input  wire logic        stall,    // hold ib_ready low
    input  wire logic        send,     // drive word next cycle
    input  wire logic [63:0] word,     // data before inversion
    output logic             ib_ready, // takes inbound transaction
    output logic             strobe,   // data phase valid
    output logic [63:0]      lines_n,  // data lines
    output logic [3:0]       flags_n   // inversion flags
);
    // per group: more than 8 lines low means sent inverted, flag low
    function automatic logic [67:0] enc(input logic [63:0] d);
        enc = 68'h0;
        for (int g = 0; g < 4; g++) begin
            enc[64+g] = ($countones(d[g*16+:16]) <= 8);
            enc[g*16+:16] = enc[64+g] ? ~d[g*16+:16] : d[g*16+:16];
        end
    endfunction
    // idle lines show the inverse so a stale word never passes for data
    always @(posedge bus_clk) begin
        ib_ready <= !stall;
        strobe <= send;
        {flags_n, lines_n} <= send ? enc(word) : ~enc(word);
    end
endmodule

// >>> host_bus_interface_dbi_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: %h vs %h", $time, a, e); end end
module host_bus_interface_dbi_tb_top;
    int n_fail = 0, compares = 0;
    logic clk = '0, rst_n = '0, bus_clk = '0, in_valid = '0, in_src = '0;
    logic in_pci_sem = '0, in_write = '0, in_noncache = '0, in_hits_memory = '0;
    logic req_valid = '0, req_io = '0, req_defer = '0, txn_done = '0;
    logic defer_done = '0, gfx_mem_en = '1, stall = '1, send = '0;
    logic [1:0] bus_rate_sel = 2'h2;
    logic [11:0] gfx_mem_base = 12'hE01, gfx_mem_limit = 12'hE01;
    logic [15:0] gfx_io_base = 16'h1000, gfx_io_limit = 16'h1FFF;
    logic [31:0] in_addr = '0, req_addr = '0, aper_base = 32'h8000_0000;
    logic [31:0] aper_mask = 32'hF000_0000, top_of_mem = 32'h1000_0000;
    logic [63:0] in_data = '0, word = 64'hFFFF_0001_FF00_7FFF;
    logic [63:0] host_data_lines_n_i, host_data_lines_n_o, rx_data;
    logic [3:0]  data_invert_flags_n_i, data_invert_flags_n_o, queue_count;
    logic [31:0] route_addr, ib_addr;
    logic [1:0]  route_target;
    logic in_posted, in_retry, rate_ok, req_ready, defer_busy, route_valid;
    logic route_translate, ib_valid, ib_kind, ib_ready, data_strobe, rx_valid;
    logic host_data_lines_oe_n, data_invert_flags_oe_n;
    // the bus clock is offset so its edges never meet the core edges
    initial forever #50 clk = ~clk;
    initial begin #37; forever #80 bus_clk = ~bus_clk; end
    host_bus_interface_dbi host_bus_interface_dbi_i (.*);
    bus_partner bus_partner_i (.bus_clk(bus_clk), .stall(stall), .send(send),
        .word(word), .ib_ready(ib_ready), .strobe(data_strobe),
        .lines_n(host_data_lines_n_i), .flags_n(data_invert_flags_n_i));
    task automatic req(logic [31:0] a, logic io, d, logic [1:0] t, logic tr);
        @(negedge bus_clk);
        {req_addr, req_io, req_defer, req_valid} = {a, io, d, 1'b1};
        while (req_ready !== 1'b1) @(negedge bus_clk);
        @(negedge bus_clk) req_valid = 1'b0;
        `CHK({route_valid, route_target, route_translate}, {1'b1, t, tr})
        `CHK(route_addr, a)
    endtask
    task automatic inb(logic [4:0] k, logic [31:0] a, output logic [1:0] got);
        @(negedge clk);
        {in_src, in_pci_sem, in_write, in_noncache, in_hits_memory} = k;
        {in_addr, in_data, in_valid} = {a, word, 1'b1};
        @(negedge clk) in_valid = 1'b0;
        got = {in_posted, in_retry};
    endtask
    task automatic t_rate();
        for (int i = 3; i >= 0; i--) begin
            @(negedge bus_clk) bus_rate_sel = 2'(i);
            repeat (3) @(negedge bus_clk);
            `CHK(rate_ok, i != 3)
        end
    endtask
    task automatic t_bus();
        req(32'h0000_0CF8, 1'b1, 1'b0, 2'h2, 1'b0);
        req(32'h0000_1234, 1'b1, 1'b0, 2'h0, 1'b0);
        req(32'h0000_3000, 1'b1, 1'b0, 2'h1, 1'b0);
        req(32'h8000_0040, 1'b0, 1'b0, 2'h3, 1'b1);
        req(32'hE010_0000, 1'b0, 1'b0, 2'h0, 1'b0);
        req(32'hF000_0000, 1'b0, 1'b0, 2'h1, 1'b0);
        req(32'h0000_1000, 1'b0, 1'b1, 2'h3, 1'b0);
        @(negedge bus_clk) req_valid = 1'b1;
        `CHK({defer_busy, req_ready}, 2'b10)
        {defer_done, req_defer} = 2'b10;
        @(negedge bus_clk) defer_done = 1'b0;
        repeat (12) @(negedge bus_clk);
        `CHK({queue_count, req_ready}, {4'hC, 1'b0})
        txn_done = 1'b1;
        @(negedge bus_clk) txn_done = 1'b0;
        `CHK({queue_count, req_ready}, {4'hB, 1'b1})
        @(negedge bus_clk) req_valid = 1'b0;
    endtask
    // inbound buffer fills while the processor side stalls
    task automatic t_inbound();
        logic [1:0] got;
        logic [67:0] pins;
        inb(5'b10011, 32'h0000_2000, got);
        `CHK(got, 2'b00)
        for (int i = 0; i < 6; i++) inb(5'b00001, 32'h0000_1047, got);
        `CHK(got, 2'b01)
        @(negedge bus_clk) stall = 1'b0;
        `CHK({ib_valid, ib_kind, ib_addr}, {2'b10, 32'h0000_1040})
        repeat (40) @(negedge bus_clk);
        inb(5'b11100, 32'hFEE0_0010, got);
        `CHK(got, 2'b10)
        while (ib_valid !== 1'b1) @(negedge bus_clk);
        `CHK({ib_kind, ib_addr}, {1'b1, 32'hFEE0_0010})
        while (host_data_lines_oe_n !== 1'b0) @(negedge bus_clk);
        pins = {data_invert_flags_n_o, host_data_lines_n_o};
        `CHK(pins, bus_partner_i.enc(word))
        `CHK(data_invert_flags_oe_n, 1'b0)
    endtask
    task automatic t_rx();
        @(negedge bus_clk) send = 1'b1;
        @(negedge bus_clk) send = 1'b0;
        while (rx_valid !== 1'b1) @(negedge bus_clk);
        `CHK(rx_data, word)
    endtask
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        t_rate();
        t_bus();
        t_inbound();
        t_rx();
        tally_and_finish();
    end
    // whole sequence needs about 17 us; far past that counts as a hang
    initial begin
        #400000;
        n_fail++;
        tally_and_finish();
    end
endmodule
bind host_bus_interface_dbi host_bus_interface_dbi_checker chk_i (.*);
